// [rtl/vsu_map.svh]
// Constants of the vector shift unit: opcodes, limits and cycle counts.
// Assumes inclusion by bare name from the shifter, the top module, the checker and the bench.
`ifndef VSU_MAP_SVH
`define VSU_MAP_SVH

// ****************************************
// Opcodes (nine-bit octal codes 150..153)
// ****************************************
`define VSU_OP_SHL        9'h068
`define VSU_OP_SHR        9'h069
`define VSU_OP_DSHL       9'h06A
`define VSU_OP_DSHR       9'h06B

// ****************************************
// Shift count limits
// ****************************************
`define VSU_SINGLE_MAX    32'h0000003F
`define VSU_DOUBLE_LIMIT  32'h00000080
`define VSU_SPECIAL_COUNT 32'h00000001

// ****************************************
// Vector geometry
// ****************************************
`define VSU_ELEMS         64

// ****************************************
// Timing in clock periods (one clock period is one cycle)
// ****************************************
`define VSU_DIRECT_EXTRA  2'h3
`define VSU_FU_EXTRA      7'h01
`define VSU_REG_EXTRA     7'h02
`define VSU_RES_EXTRA     7'h02
`define VSU_RES_EXTRA_L   7'h03

// ****************************************
// Result buffer
// ****************************************
`define VSU_BUF_DEPTH     2

`endif

// [rtl/vsu_pkg.sv]
// Types shared by the vector shift unit modules.
// Assumes nothing beyond a SystemVerilog compiler.
package vsu_pkg;

    // Operation kinds, one-hot.
    typedef enum logic [3:0] {
        VSU_SHL  = 4'h1,
        VSU_SHR  = 4'h2,
        VSU_DSHL = 4'h4,
        VSU_DSHR = 4'h8
    } vsu_op_t;

    // Read engine states, one-hot.
    typedef enum logic [1:0] {
        VSU_RD_IDLE = 2'h1,
        VSU_RD_RUN  = 2'h2
    } vsu_rd_state_t;

    // One instruction as held in the unit.
    typedef struct packed {
        vsu_op_t     op;
        logic [31:0] cnt;
        logic [2:0]  dst;
        logic [2:0]  src;
    } vsu_job_t;

    // One destination element write.
    typedef struct packed {
        logic [2:0]  reg_n;
        logic [5:0]  idx;
        logic [63:0] data;
    } vsu_wr_t;

endpackage

// [rtl/vsu_elem_if.sv]
// Element write channel between the shift pipeline and its result buffer.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface vsu_elem_if;
    logic             valid;  // Word offered.
    logic             ready;  // Word may be taken.
    vsu_pkg::vsu_wr_t word;   // Element write.
    modport src (output valid, output word, input ready);
    modport snk (input valid, input word, output ready);
endinterface
`default_nettype wire

// [rtl/vsu_shifter.sv]
// End-off zero-fill shifter for single and double element shifts.
// Assumes a purely combinational use; the result buffer registers it.
`timescale 1ns/10ps
`default_nettype none
`include "vsu_map.svh"
module vsu_shifter (
    // Operation
    input  wire vsu_pkg::vsu_op_t op_in,
    input  wire logic [31:0]      cnt_in,
    // Operands, high half and low half
    input  wire logic [63:0]      hi_in,
    input  wire logic [63:0]      lo_in,
    // Result
    output logic [63:0]           res_out
);
    logic [127:0] wide;  // Joined operands after the shift.

    // Picks the shift and zeroes results whose count is out of range.
    always_comb begin
        wide    = '0;
        res_out = '0;
        case (op_in)
            vsu_pkg::VSU_SHL: begin
                if (cnt_in <= `VSU_SINGLE_MAX) res_out = lo_in << cnt_in[5:0];
            end
            vsu_pkg::VSU_SHR: begin
                if (cnt_in <= `VSU_SINGLE_MAX) res_out = lo_in >> cnt_in[5:0];
            end
            vsu_pkg::VSU_DSHL: begin
                if (cnt_in < `VSU_DOUBLE_LIMIT) wide = {hi_in, lo_in} << cnt_in[6:0];
                res_out = wide[127:64];
            end
            vsu_pkg::VSU_DSHR: begin
                if (cnt_in < `VSU_DOUBLE_LIMIT) wide = {hi_in, lo_in} >> cnt_in[6:0];
                res_out = wide[63:0];
            end
            default: res_out = '0;
        endcase
    end
endmodule // vsu_shifter
`default_nettype wire

// [rtl/vsu_fifo.sv]
// Result buffer: a small circular FIFO for element writes.
// Assumes the receiver may hold ready low for any number of cycles.
`timescale 1ns/10ps
`default_nettype none
module vsu_fifo #(
    parameter int WIDTH = 73,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    // Filling side
    vsu_elem_if.snk               push,
    // Draining side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Refuses shapes the pointer arithmetic cannot serve.
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH != $bits(vsu_pkg::vsu_wr_t))
            $error("vsu_fifo: bad WIDTH or DEPTH");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;  // Stored words.
        logic [PW-1:0]               rp;   // Read pointer.
        logic [PW-1:0]               wp;   // Write pointer.
        logic [PW:0]                 cnt;  // Words held.
    } vsu_fifo_state_t;

    vsu_fifo_state_t r;       // Registered state.
    vsu_fifo_state_t next_r;  // Next state.
    logic            do_push; // Word enters.
    logic            do_pop;  // Word leaves.

    assign push.ready    = (r.cnt != (PW+1)'(DEPTH));
    assign out_valid_out = (r.cnt != '0);
    assign out_data_out  = r.mem[r.rp];
    assign do_push       = push.valid && push.ready;
    assign do_pop        = out_valid_out && out_ready_in;

    // Moves pointers and count; push and pop may share a cycle.
    always_comb begin
        next_r = r;
        if (do_push) begin
            next_r.mem[r.wp] = push.word;
            next_r.wp        = r.wp + 1'b1;
        end
        if (do_pop) next_r.rp = r.rp + 1'b1;
        if (do_push && !do_pop) next_r.cnt = r.cnt + 1'b1;
        else if (do_pop && !do_push) next_r.cnt = r.cnt - 1'b1;
    end

    // Registers the state; reset empties the buffer.
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) r <= '0;
        else r <= next_r;
    end
endmodule // vsu_fifo
`default_nettype wire

// [rtl/vsu_top.sv]
// Vector shift functional unit: issue holds, timing and element pipeline.
// Assumes a register file read port that answers in the same cycle and
// issue logic that keeps its own reservations from the pulses given here.
`timescale 1ns/10ps
`default_nettype none
`include "vsu_map.svh"
module vsu_top #(
    parameter int ELEMS = `VSU_ELEMS
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // Instruction issue stage
    input  wire logic        cip_valid_in,
    input  wire logic [8:0]  cip_opcode_in,
    input  wire logic [2:0]  cip_i_in,
    input  wire logic [2:0]  cip_j_in,
    input  wire logic [2:0]  cip_k_in,
    input  wire logic [31:0] shift_count_addr_reg_in,
    input  wire logic        count_reg_reserved_in,
    input  wire logic        op077_prev_in,
    input  wire logic        op035_037_busy_in,
    input  wire logic        viq_full_in,
    input  wire logic        half_rate_cpu_in,
    input  wire logic        sys_clk_phase_in,
    output logic             cip_accept_out,
    // Vector issue stage
    input  wire logic [6:0]  vector_length_reg_in,
    input  wire logic        dest_reserved_in,
    input  wire logic        src_reserved_in,
    input  wire logic        chain_ok_in,
    input  wire logic        src_not_chaining_in,
    output logic             vir_valid_out,
    output logic [2:0]       vir_dst_out,
    output logic [2:0]       vir_src_out,
    output logic             dispatch_out,
    output logic             fu_busy_out,
    // Release pulses
    output logic             dest_free_out,
    output logic [2:0]       dest_free_reg_out,
    output logic             src_free_out,
    output logic [2:0]       src_free_reg_out,
    output logic             result_ready_out,
    output logic [2:0]       result_reg_out,
    // Source read port
    output logic             rd_en_out,
    output logic [2:0]       rd_reg_out,
    output logic [5:0]       rd_idx_out,
    input  wire logic [63:0] rd_data_in,
    // Destination write port
    output logic             wr_valid_out,
    input  wire logic        wr_ready_in,
    output logic [2:0]       wr_reg_out,
    output logic [5:0]       wr_idx_out,
    output logic [63:0]      wr_data_out
);
    // Refuses a register length the index widths cannot carry.
    initial begin
        if (ELEMS < 1 || ELEMS > `VSU_ELEMS) $error("vsu_top: ELEMS out of range");
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic                   v_valid;   // Vector issue stage holds a job.
        logic [1:0]             v_settle;  // Cycles left before it may go.
        vsu_pkg::vsu_job_t      v_job;     // Job waiting there.
        vsu_pkg::vsu_rd_state_t rd_state;  // Read engine state.
        vsu_pkg::vsu_job_t      rd_job;    // Job being read.
        logic [5:0]             rd_idx;    // Next source element.
        logic [6:0]             rd_vl;     // Length of that job.
        logic [6:0]             fu_cnt;    // Busy countdown.
        logic                   s_v;       // Shift stage holds an element.
        vsu_pkg::vsu_job_t      s_job;     // Its job.
        logic [5:0]             s_idx;     // Its element index.
        logic                   s_last;    // Last element of the job.
        logic                   s_tail;    // Left double final pairing.
        logic [63:0]            s_data;    // Its source element.
        logic [63:0]            prev;      // Previous source element.
        logic [1:0][6:0]        dcnt;      // Destination release countdowns.
        logic [1:0][6:0]        scnt;      // Source release countdowns.
        logic [1:0][6:0]        rcnt;      // Result ready countdowns.
        logic [1:0][2:0]        dreg;      // Destination per slot.
        logic [1:0][2:0]        sreg;      // Source per slot.
        logic                   slot;      // Next slot to fill.
    } vsu_state_t;

    vsu_state_t        r;         // Registered state.
    vsu_state_t        next_r;    // Next state.
    vsu_pkg::vsu_op_t  dec_op;    // Decoded opcode.
    logic              legal;     // Opcode belongs to this unit.
    logic              hold;      // Issue stage hold.
    logic              dispatch;  // Job leaves the vector issue stage.
    logic              rd_fire;   // Source element read this cycle.
    logic              left;      // Shift stage job is a left double.
    logic              absorb;    // First left element only seeds prev.
    logic              push_fire; // Element write enters the buffer.
    logic              consume;   // Shift stage element is used up.
    logic              go_tail;   // Stage stays for the final pairing.
    logic              s_free;    // Stage can take a new element.
    logic [63:0]       sh_hi;     // Shifter high operand.
    logic [63:0]       sh_lo;     // Shifter low operand.
    logic [63:0]       sh_res;    // Shifter result.
    logic [1:0]        d_hit;     // Destination pulse per slot.
    logic [1:0]        s_hit;     // Source pulse per slot.
    logic [1:0]        r_hit;     // Result pulse per slot.
    vsu_pkg::vsu_wr_t  buf_word;  // Buffer output word.

    vsu_elem_if elem ();

    // ****************************************
    // Decode and issue holds
    // ****************************************

    // Maps the opcode to an operation kind.
    always_comb begin
        legal  = 1'b1;
        dec_op = vsu_pkg::VSU_SHL;
        case (cip_opcode_in)
            `VSU_OP_SHL:  dec_op = vsu_pkg::VSU_SHL;
            `VSU_OP_SHR:  dec_op = vsu_pkg::VSU_SHR;
            `VSU_OP_DSHL: dec_op = vsu_pkg::VSU_DSHL;
            `VSU_OP_DSHR: dec_op = vsu_pkg::VSU_DSHR;
            default:      legal  = 1'b0;
        endcase
    end

    // A reserved count register holds unless it is register zero.
    assign hold = (count_reg_reserved_in && cip_k_in != 3'h0)
                  || op077_prev_in || op035_037_busy_in || viq_full_in || r.v_valid
                  || ((dec_op == vsu_pkg::VSU_DSHL || dec_op == vsu_pkg::VSU_DSHR)
                      && half_rate_cpu_in && !sys_clk_phase_in);
    assign cip_accept_out = cip_valid_in && legal && !hold;

    // Leaves the vector issue stage only with a free unit and free or chainable registers.
    assign dispatch = r.v_valid && r.v_settle == 2'h0 && !fu_busy_out
                      && r.rd_state == vsu_pkg::VSU_RD_IDLE
                      && !((dest_reserved_in || src_reserved_in) && !chain_ok_in);
    assign fu_busy_out   = r.fu_cnt != 7'h00;
    assign vir_valid_out = r.v_valid;
    assign vir_dst_out   = r.v_job.dst;
    assign vir_src_out   = r.v_job.src;
    assign dispatch_out  = dispatch;

    // ****************************************
    // Element pipeline
    // ****************************************
    assign left      = r.s_job.op == vsu_pkg::VSU_DSHL;
    assign absorb    = r.s_v && left && !r.s_tail && r.s_idx == 6'h00;
    assign push_fire = r.s_v && !absorb && elem.ready;
    assign consume   = absorb || push_fire;
    assign go_tail   = consume && left && r.s_last && !r.s_tail;
    assign s_free    = !r.s_v || (consume && !go_tail);
    assign rd_fire   = r.rd_state == vsu_pkg::VSU_RD_RUN && s_free;    // Stall on back-pressure.
    assign rd_en_out  = rd_fire;
    assign rd_reg_out = r.rd_job.src;
    assign rd_idx_out = r.rd_idx;

    // Chooses the halves that are joined for each kind of shift.
    always_comb begin
        sh_lo = r.s_data;
        sh_hi = r.prev;
        if (r.s_tail) begin
            sh_hi = r.s_data;
            sh_lo = '0;
        end else if (r.s_job.op == vsu_pkg::VSU_DSHR && r.s_idx == 6'h00) begin
            sh_hi = '0;
        end
    end

    vsu_shifter u_shift (
        .op_in   (r.s_job.op),
        .cnt_in  (r.s_job.cnt),
        .hi_in   (sh_hi),
        .lo_in   (sh_lo),
        .res_out (sh_res)
    );

    // A left pairing writes the element before the one just read.
    assign elem.valid       = r.s_v && !absorb;
    assign elem.word.reg_n  = r.s_job.dst;
    assign elem.word.idx    = (left && !r.s_tail) ? r.s_idx - 6'h01 : r.s_idx;
    assign elem.word.data   = sh_res;

    vsu_fifo #(
        .WIDTH ($bits(vsu_pkg::vsu_wr_t)),
        .DEPTH (`VSU_BUF_DEPTH)
    ) u_buf (
        .clk_in        (clk_in),
        .reset_n_in    (reset_n_in),
        .push          (elem),
        .out_valid_out (wr_valid_out),
        .out_ready_in  (wr_ready_in),
        .out_data_out  (buf_word)
    );
    assign wr_reg_out  = buf_word.reg_n;
    assign wr_idx_out  = buf_word.idx;
    assign wr_data_out = buf_word.data;

    // ****************************************
    // Release pulses
    // ****************************************
    for (genvar g = 0; g < 2; g++) begin : g_slot
        assign d_hit[g] = r.dcnt[g] == 7'h01;
        assign s_hit[g] = r.scnt[g] == 7'h01;
        assign r_hit[g] = r.rcnt[g] == 7'h01;
    end
    assign dest_free_out     = |d_hit;
    assign dest_free_reg_out = d_hit[0] ? r.dreg[0] : r.dreg[1];
    assign result_ready_out  = |r_hit;
    assign result_reg_out    = r_hit[0] ? r.dreg[0] : r.dreg[1];
    // Source frees at once when nothing chains from it.
    assign src_free_out      = |s_hit || (dispatch && src_not_chaining_in);
    assign src_free_reg_out  = (dispatch && src_not_chaining_in) ? r.v_job.src
                             : (s_hit[0] ? r.sreg[0] : r.sreg[1]);

    // ****************************************
    // Next state
    // ****************************************

    // Advances issue stages, counters and the element pipeline.
    always_comb begin
        next_r = r;
        // Vector issue stage entry and settling.
        if (r.v_settle != 2'h0) next_r.v_settle = r.v_settle - 2'h1;
        if (cip_accept_out) begin
            next_r.v_valid    = 1'b1;
            next_r.v_settle   = `VSU_DIRECT_EXTRA;
            next_r.v_job.op   = dec_op;
            next_r.v_job.dst  = cip_i_in;
            next_r.v_job.src  = cip_j_in;
            next_r.v_job.cnt  = (cip_k_in == 3'h0) ? `VSU_SPECIAL_COUNT
                                                   : shift_count_addr_reg_in;
        end
        // Countdowns.
        if (r.fu_cnt != 7'h00) next_r.fu_cnt = r.fu_cnt - 7'h01;
        for (int i = 0; i < 2; i++) begin
            if (r.dcnt[i] != 7'h00) next_r.dcnt[i] = r.dcnt[i] - 7'h01;
            if (r.scnt[i] != 7'h00) next_r.scnt[i] = r.scnt[i] - 7'h01;
            if (r.rcnt[i] != 7'h00) next_r.rcnt[i] = r.rcnt[i] - 7'h01;
        end
        // Dispatch loads the read engine and a release slot.
        if (dispatch) begin
            next_r.v_valid  = 1'b0;
            next_r.fu_cnt   = vector_length_reg_in + `VSU_FU_EXTRA - 7'h01;
            next_r.rd_job   = r.v_job;
            next_r.rd_idx   = 6'h00;
            next_r.rd_vl    = vector_length_reg_in;
            next_r.rd_state = (vector_length_reg_in == 7'h00) ? vsu_pkg::VSU_RD_IDLE
                                                              : vsu_pkg::VSU_RD_RUN;
            next_r.dcnt[r.slot] = vector_length_reg_in + `VSU_REG_EXTRA;
            next_r.scnt[r.slot] = src_not_chaining_in ? 7'h00
                                : vector_length_reg_in + `VSU_REG_EXTRA;
            next_r.rcnt[r.slot] = vector_length_reg_in
                                + ((r.v_job.op == vsu_pkg::VSU_DSHL) ? `VSU_RES_EXTRA_L
                                                                     : `VSU_RES_EXTRA);
            next_r.dreg[r.slot] = r.v_job.dst;
            next_r.sreg[r.slot] = r.v_job.src;
            next_r.slot         = !r.slot;
        end
        // Shift stage drains.
        if (consume) begin
            next_r.prev = r.s_data;
            if (go_tail) next_r.s_tail = 1'b1;
            else next_r.s_v = 1'b0;
        end
        // Source read fills the shift stage; reads stop at length minus one.
        case (r.rd_state)
            vsu_pkg::VSU_RD_IDLE: begin
            end
            vsu_pkg::VSU_RD_RUN: begin
                if (rd_fire) begin
                    next_r.s_v    = 1'b1;
                    next_r.s_job  = r.rd_job;
                    next_r.s_idx  = r.rd_idx;
                    next_r.s_tail = 1'b0;
                    next_r.s_data = rd_data_in;
                    next_r.s_last = {1'b0, r.rd_idx} == r.rd_vl - 7'h01;
                    next_r.rd_idx = r.rd_idx + 6'h01;
                    if ({1'b0, r.rd_idx} == r.rd_vl - 7'h01) next_r.rd_state = vsu_pkg::VSU_RD_IDLE;
                end
            end
            default: next_r.rd_state = vsu_pkg::VSU_RD_IDLE;
        endcase
    end

    // Registers the state; reset leaves every stage empty and idle.
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            r          <= '0;
            r.rd_state <= vsu_pkg::VSU_RD_IDLE;
        end else begin
            r <= next_r;
        end
    end
endmodule // vsu_top
`default_nettype wire

// [verif/vsu_top_sva.sv]
// Checker of issue holds, release timing and write-port hold for vsu_top.
// Assumes binding to vsu_top, all signals on clk_in.
`timescale 1ns/10ps
`default_nettype none
`include "vsu_map.svh"
module vsu_top_sva #(parameter int ELEMS = 64) (
    input wire logic clk_in, reset_n_in, cip_valid_in, count_reg_reserved_in, op077_prev_in, op035_037_busy_in,
    input wire logic viq_full_in, half_rate_cpu_in, sys_clk_phase_in, cip_accept_out, dest_reserved_in,
    input wire logic src_reserved_in, chain_ok_in, src_not_chaining_in, dispatch_out, fu_busy_out,
    input wire logic dest_free_out, src_free_out, result_ready_out, wr_valid_out, wr_ready_in,
    input wire logic [8:0]  cip_opcode_in,
    input wire logic [2:0]  cip_k_in,
    input wire logic [6:0]  vector_length_reg_in,
    input wire logic [63:0] wr_data_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    logic [8:0] op_q; // Opcode of the job waiting in the vector issue stage.
    always_ff @(posedge clk_in) if (cip_accept_out) op_q <= cip_opcode_in;
    issue_hold_a: assert property (
        cip_accept_out |-> !op077_prev_in && !op035_037_busy_in && !viq_full_in
        && !(count_reg_reserved_in && cip_k_in != 3'h0)) else $error("accept during hold");
    legal_op_a: assert property (
        cip_accept_out |-> cip_valid_in && cip_opcode_in inside {[`VSU_OP_SHL:`VSU_OP_DSHR]}) else $error("bad accept");
    clock_align_a: assert property (
        cip_accept_out && half_rate_cpu_in && cip_opcode_in[8:1] == 8'h35 |-> sys_clk_phase_in) else $error("phase");
    direct_path_a: assert property (
        cip_accept_out |=> !dispatch_out [*3]) else $error("dispatch too early");
    vir_hold_a: assert property (
        dispatch_out |-> !fu_busy_out && (chain_ok_in || !(dest_reserved_in || src_reserved_in))) else $error("vir");
    unit_busy_a: assert property (
        dispatch_out && vector_length_reg_in == 7'h03 |=> fu_busy_out [*3] ##1 !fu_busy_out) else $error("busy");
    dest_free_a: assert property (
        dispatch_out && vector_length_reg_in == 7'h02 |-> ##4 dest_free_out) else $error("dest free");
    src_free_a: assert property (
        dispatch_out && src_not_chaining_in |-> src_free_out) else $error("src free");
    left_result_a: assert property (
        dispatch_out && op_q == `VSU_OP_DSHL && vector_length_reg_in == 7'h02 |-> ##5 result_ready_out)
        else $error("result");
    write_hold_a: assert property (
        wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable(wr_data_out)) else $error("word dropped");
endmodule // vsu_top_sva
`default_nettype wire

// [verif/vsu_regfile_model.sv]
// Register file partner: same-cycle source reads and a stalling write port.
// Assumes the bench fills mem before the first read.
`timescale 1ns/10ps
`default_nettype none
module vsu_regfile_model (
    input wire logic        clk_in, rd_en_in, slow_in,
    input wire logic [5:0]  rd_idx_in,
    output logic [63:0]     rd_data_out,
    output logic            wr_ready_out
);
    logic [63:0] mem [64];     // Source elements.
    logic [1:0]  tick = 2'h0;  // Stall pacing.
    // Off-cycle data is inverted so a late sample cannot pass by luck.
    assign rd_data_out = rd_en_in ? mem[rd_idx_in] : ~mem[rd_idx_in];
    assign wr_ready_out = !slow_in || tick == 2'h0;
    always @(posedge clk_in) tick <= tick + 2'h1;
endmodule // vsu_regfile_model
`default_nettype wire

// [verif/vector_shift_unit_tb_top.sv]
// Self-checking bench: issues shifts under random holds, checks every write.
// Assumes vsu_top, its package and the register file model.
`timescale 1ns/10ps
`default_nettype none
`include "vsu_map.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t bad write", $time); end end
module vector_shift_unit_tb_top;
    logic clk_in = 1'h0, reset_n_in = 1'h0, cip_valid_in = 1'h0, count_reg_reserved_in = 1'h0, op077_prev_in = 1'h0;
    logic op035_037_busy_in = 1'h0, viq_full_in = 1'h0, sys_clk_phase_in = 1'h0, dest_reserved_in = 1'h0;
    logic src_reserved_in = 1'h0, chain_ok_in = 1'h0, src_not_chaining_in = 1'h0, slow = 1'h0;
    logic cip_accept_out, vir_valid_out, rd_en_out, wr_valid_out, wr_ready_in;
    logic [8:0]  cip_opcode_in = 9'h000;
    logic [2:0]  cip_i_in = 3'h0, cip_j_in = 3'h0, cip_k_in = 3'h0, wr_reg_out;
    logic [5:0]  rd_idx_out, wr_idx_out;
    logic [6:0]  vector_length_reg_in = 7'h00;
    logic [31:0] shift_count_addr_reg_in = 32'h0, hv;
    logic [63:0] rd_data_in, wr_data_out;
    logic [72:0] e, q [$];  // Expected writes: register, index, data.
    int seed = 32'hA59F04C8, mismatches = 0, checks_done = 0, i;
    logic [8:0]  ops [4] = '{`VSU_OP_SHL, `VSU_OP_SHR, `VSU_OP_DSHL, `VSU_OP_DSHR};
    logic [31:0] cnts [8] = '{32'h0000FFFF, 32'h3, 32'h3F, 32'h40, 32'h41, 32'h7F, 32'h80, 32'hFFFFFFFF};
    always #12.5 clk_in = ~clk_in;
    vsu_top #(.ELEMS(64)) uut (.clk_in, .reset_n_in, .cip_valid_in, .cip_opcode_in, .cip_i_in, .cip_j_in,
        .cip_k_in, .shift_count_addr_reg_in, .count_reg_reserved_in, .op077_prev_in, .op035_037_busy_in,
        .viq_full_in, .half_rate_cpu_in(!slow), .sys_clk_phase_in, .cip_accept_out, .vector_length_reg_in,
        .dest_reserved_in, .src_reserved_in, .chain_ok_in, .src_not_chaining_in, .vir_valid_out, .vir_dst_out(),
        .vir_src_out(), .dispatch_out(), .fu_busy_out(), .dest_free_out(), .dest_free_reg_out(), .src_free_out(),
        .src_free_reg_out(), .result_ready_out(), .result_reg_out(), .rd_en_out, .rd_reg_out(), .rd_idx_out,
        .rd_data_in, .wr_valid_out, .wr_ready_in, .wr_reg_out, .wr_idx_out, .wr_data_out);
    vsu_regfile_model pm (.clk_in, .rd_en_in(rd_en_out), .slow_in(slow), .rd_idx_in(rd_idx_out),
        .rd_data_out(rd_data_in), .wr_ready_out(wr_ready_in));
    // Hold conditions and reservations come and go at random.
    always @(posedge clk_in) begin
        hv = $random(seed) & $random(seed);
        {op077_prev_in, op035_037_busy_in, viq_full_in, count_reg_reserved_in} <= hv[3:0];
        {dest_reserved_in, src_reserved_in, chain_ok_in, src_not_chaining_in} <= hv[7:4];
        sys_clk_phase_in <= ~sys_clk_phase_in;
    end
    // Expected element from the source contents, op, count and length.
    function automatic logic [63:0] expv(logic [8:0] op, logic [31:0] c, int n, int l);
        logic [127:0] v;
        if (op == `VSU_OP_SHL) return (c > 32'h3F) ? 64'h0 : pm.mem[n] << c;
        if (op == `VSU_OP_SHR) return (c > 32'h3F) ? 64'h0 : pm.mem[n] >> c;
        if (c >= 32'h80) return 64'h0;
        if (op == `VSU_OP_DSHL) v = {pm.mem[n], (n + 1 < l) ? pm.mem[n + 1] : 64'h0} << c;
        else v = {(n == 0) ? 64'h0 : pm.mem[n - 1], pm.mem[n]} >> c;
        return (op == `VSU_OP_DSHL) ? v[127:64] : v[63:0];
    endfunction
    task automatic final_report();
        if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Waits for the stage to empty, offers one job, and notes its writes.
    task automatic issue(logic [8:0] op, logic [2:0] k, logic [31:0] c, logic [6:0] l);
        int t;
        logic [2:0] d;
        d = cip_i_in + 3'h1;
        for (t = 0; t < 300; t++) begin @(posedge clk_in); if (vir_valid_out === 1'b0) break; end
        if (t == 300) begin mismatches++; final_report(); end
        {cip_opcode_in, cip_k_in, shift_count_addr_reg_in, vector_length_reg_in} <= {op, k, c, l};
        {cip_i_in, cip_j_in, cip_valid_in} <= {d, 3'h5, 1'h1};
        for (t = 0; t < 300; t++) begin @(posedge clk_in); if (cip_accept_out === 1'b1) break; end
        cip_valid_in <= 1'h0;
        if (t == 300) begin mismatches++; final_report(); end
        for (t = 0; t < l; t++) q.push_back({d, 6'(t), expv(op, (k == 3'h0) ? 32'h1 : c, t, l)});
    endtask
    // Every write taken is matched against the oldest note.
    always @(posedge clk_in) if (reset_n_in && wr_valid_out === 1'b1 && wr_ready_in === 1'b1) begin
        e = (q.size() != 0) ? q.pop_front() : {73{1'bx}};
        `CHK({wr_reg_out, wr_idx_out, wr_data_out}, e)
    end
    initial begin
        for (i = 0; i < 64; i++) pm.mem[i] = {$random(seed), $random(seed)};
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'h1;
        for (i = 0; i < 32; i++) begin
            slow <= i[2];
            issue(ops[i % 4], (i < 4) ? 3'h0 : 3'h3, cnts[i / 4], 7'(1 + i % 5));
        end
        issue(`VSU_OP_DSHL, 3'h2, 32'h5, 7'h40);
        issue(`VSU_OP_DSHR, 3'h2, 32'h41, 7'h40);
        issue(`VSU_OP_SHL, 3'h1, 32'h2, 7'h00);
        for (i = 0; i < 3000 && q.size() != 0; i++) @(posedge clk_in);
        if (q.size() != 0) mismatches++;
        final_report();
    end
endmodule // vector_shift_unit_tb_top
bind vsu_top vsu_top_sva #(.ELEMS(ELEMS)) chk (.clk_in, .reset_n_in, .cip_valid_in, .count_reg_reserved_in,
    .op077_prev_in, .op035_037_busy_in, .viq_full_in, .half_rate_cpu_in, .sys_clk_phase_in, .cip_accept_out,
    .dest_reserved_in, .src_reserved_in, .chain_ok_in, .src_not_chaining_in, .dispatch_out, .fu_busy_out,
    .dest_free_out, .src_free_out, .result_ready_out, .wr_valid_out, .wr_ready_in, .cip_opcode_in, .cip_k_in,
    .vector_length_reg_in, .wr_data_out);
`default_nettype wire
